/* rtl/dcc_top.sv */
// dual comparator control: registers, synchronisers, edge flags, output gating
// assumes two analog cores giving raw results and an apb master on pclk
`timescale 1ns/100ps

module dcc_top #(
  parameter int NCH = 2 // channel count
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low active
  input wire logic clk_en, // freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [1:0] cmp_raw_in, // analog core results
  output logic [1:0] cmp_enable, // power-up to cores
  output logic [1:0] cmp0_pos_input_sel, // ch0 positive mux
  output logic [1:0] cmp0_neg_input_sel, // ch0 negative mux
  output logic [1:0] cmp1_pos_input_sel, // ch1 positive mux
  output logic [1:0] cmp1_neg_input_sel, // ch1 negative mux
  output logic [3:0] cmp_pos_hyst_sel, // {ch1,ch0} positive hysteresis
  output logic [3:0] cmp_neg_hyst_sel, // {ch1,ch0} negative hysteresis
  output logic [3:0] cmp_response_sel, // {ch1,ch0} response mode
  output logic cmp0_latched_out, // ch0 synced pin output
  output logic cmp1_latched_out, // ch1 synced pin output
  output logic cmp0_raw_out, // ch0 unclocked pin output
  output logic cmp1_raw_out, // ch1 unclocked pin output
  output logic [1:0] cmp_irq, // per-channel interrupt request
  output logic cmp0_reset_req // ch0 reset source output
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NCH != 2) begin : g_chk
    $error("dcc_top serves exactly two channels");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && clk_en;
  wire logic rd_setup = clk_en && psel && !penable && !pwrite;
  wire logic hit_c0 = paddr == dcc_pkg::OFF_CTRL0;
  wire logic hit_m0 = paddr == dcc_pkg::OFF_MODE0;
  wire logic hit_x0 = paddr == dcc_pkg::OFF_ISEL0;
  wire logic hit_c1 = paddr == dcc_pkg::OFF_CTRL1;
  wire logic hit_m1 = paddr == dcc_pkg::OFF_MODE1;
  wire logic hit_x1 = paddr == dcc_pkg::OFF_ISEL1;
  wire logic hit_any = hit_c0 | hit_m0 | hit_x0 | hit_c1 | hit_m1 | hit_x1;
  wire logic [1:0] wr_ctrl = {wr && hit_c1, wr && hit_c0};
  wire logic [1:0] wr_mode = {wr && hit_m1, wr && hit_m0};
  wire logic [1:0] wr_isel = {wr && hit_x1, wr && hit_x0};

  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl [2]; // enable and hysteresis bits only
  logic [7:0] mode [2];
  logic [7:0] isel [2];
  logic [1:0] sync1, sync2, prev;
  logic [1:0] rise_flag, fall_flag;

  // edge detection on synchronised result, only while the core is powered
  wire logic [1:0] rise_ev = sync2 & ~prev & cmp_enable;
  wire logic [1:0] fall_ev = ~sync2 & prev & cmp_enable;

  // writable register bits per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i] <= dcc_pkg::RST_CTRL;
        mode[i] <= dcc_pkg::RST_MODE;
        isel[i] <= dcc_pkg::RST_ISEL;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctrl[i]) ctrl[i] <= pwdata[7:0] & dcc_pkg::MASK_CTRL_WR;
        if (wr_mode[i]) mode[i] <= pwdata[7:0] & dcc_pkg::MASK_MODE;
        if (wr_isel[i]) isel[i] <= pwdata[7:0] & dcc_pkg::MASK_ISEL;
      end
    end
  end

  // two-flop synchroniser then edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev <= 2'h0;
    end else if (clk_en) begin
      sync1 <= cmp_raw_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // sticky flags: edge set wins over software write of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_flag <= 2'h0;
      fall_flag <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (rise_ev[i]) rise_flag[i] <= 1'b1;
        else if (wr_ctrl[i]) rise_flag[i] <= pwdata[dcc_pkg::CTL_RIF];
        if (fall_ev[i]) fall_flag[i] <= 1'b1;
        else if (wr_ctrl[i]) fall_flag[i] <= pwdata[dcc_pkg::CTL_FIF];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  function automatic logic [7:0] ctrl_view(input logic [7:0] c, input logic o,
                                           input logic r, input logic f);
    logic [7:0] v;
    v = c;
    v[dcc_pkg::CTL_OUT] = o;
    v[dcc_pkg::CTL_RIF] = r;
    v[dcc_pkg::CTL_FIF] = f;
    return v;
  endfunction

  wire logic [7:0] en_res = {6'h00, sync2 & cmp_enable};
  wire logic [7:0] rd_c0 = ctrl_view(ctrl[0], en_res[0], rise_flag[0], fall_flag[0]);
  wire logic [7:0] rd_c1 = ctrl_view(ctrl[1], en_res[1], rise_flag[1], fall_flag[1]);
  wire logic [7:0] rd_sel = hit_c0 ? rd_c0 : hit_m0 ? mode[0] : hit_x0 ? isel[0] :
                            hit_c1 ? rd_c1 : hit_m1 ? mode[1] : hit_x1 ? isel[1] : 8'h00;

  // registered read data, captured at the edge that ends the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= {24'h00_0000, rd_sel};
  end

  // ----------------------------------------------------------------
  // analog core controls
  // ----------------------------------------------------------------
  assign cmp_enable = {ctrl[1][dcc_pkg::CTL_EN], ctrl[0][dcc_pkg::CTL_EN]};
  assign cmp0_pos_input_sel = isel[0][dcc_pkg::MX_POS +: 2];
  assign cmp0_neg_input_sel = isel[0][dcc_pkg::MX_NEG +: 2];
  assign cmp1_pos_input_sel = isel[1][dcc_pkg::MX_POS +: 2];
  assign cmp1_neg_input_sel = isel[1][dcc_pkg::MX_NEG +: 2];
  // hysteresis codes passed through unchanged
  assign cmp_pos_hyst_sel = {ctrl[1][dcc_pkg::CTL_HYP +: 2],
                             ctrl[0][dcc_pkg::CTL_HYP +: 2]};
  assign cmp_neg_hyst_sel = {ctrl[1][dcc_pkg::CTL_HYN +: 2],
                             ctrl[0][dcc_pkg::CTL_HYN +: 2]};
  assign cmp_response_sel = {mode[1][dcc_pkg::MD_RSP +: 2],
                             mode[0][dcc_pkg::MD_RSP +: 2]};

  // ----------------------------------------------------------------
  // pin outputs and interrupts
  // ----------------------------------------------------------------
  // raw path is pure gating, usable without pclk
  assign cmp0_raw_out = cmp_raw_in[0] & cmp_enable[0];
  assign cmp1_raw_out = cmp_raw_in[1] & cmp_enable[1];
  assign cmp0_latched_out = en_res[0];
  assign cmp1_latched_out = en_res[1];
  assign cmp0_reset_req = cmp_enable[0] & ~sync2[0];

  wire logic [1:0] rie = {mode[1][dcc_pkg::MD_RIE], mode[0][dcc_pkg::MD_RIE]};
  wire logic [1:0] fie = {mode[1][dcc_pkg::MD_FIE], mode[0][dcc_pkg::MD_FIE]};
  assign cmp_irq = (rise_flag & rie) | (fall_flag & fie);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // rise edge on channel 0 sets its flag
  AST_RISE_SET: assert property (clk_en && rise_ev[0] ##1 clk_en |-> rise_flag[0])
    else $error("rise edge did not set flag");

  // rise edge on channel 1 sets its flag
  AST_RISE_SET1: assert property (clk_en && rise_ev[1] |=> rise_flag[1])
    else $error("rise edge did not set flag on channel 1");

  // fall edge on channel 1 sets its flag
  AST_FALL_SET: assert property (clk_en && fall_ev[1] |=> fall_flag[1])
    else $error("fall edge did not set flag");

  // fall edge on channel 0 sets its flag
  AST_FALL_SET0: assert property (clk_en && fall_ev[0] |=> fall_flag[0])
    else $error("fall edge did not set flag on channel 0");

  // channel 0 rise flag holds until a control write
  AST_STICKY: assert property (rise_flag[0] && !wr_ctrl[0] |=> rise_flag[0])
    else $error("rise flag dropped without write");

  // channel 1 rise flag holds too
  AST_STICKY_R1: assert property (rise_flag[1] && !wr_ctrl[1] |=> rise_flag[1])
    else $error("rise flag 1 dropped without write");

  // channel 1 fall flag holds too
  AST_STICKY_F1: assert property (fall_flag[1] && !wr_ctrl[1] |=> fall_flag[1])
    else $error("fall flag 1 dropped without write");

  // writing zero with no edge clears the flag
  AST_CLR: assert property (wr_ctrl[0] && !pwdata[5] && !rise_ev[0] |=> !rise_flag[0])
    else $error("rise flag not cleared by write");

  // frozen clock enable keeps flags
  AST_FREEZE: assert property (!clk_en |=> $stable(rise_flag) && $stable(fall_flag))
    else $error("flags moved while frozen");

  // synchroniser is exactly two flops deep
  AST_SYNC: assert property (clk_en ##1 clk_en ##1 1'b1 |-> sync2 == $past(cmp_raw_in, 2))
    else $error("synchroniser depth wrong");

  // disabled channel 1 drives its pins low
  AST_GATE: assert property (!cmp_enable[1] |-> !cmp1_latched_out && !cmp1_raw_out)
    else $error("disabled output not low");

  // disabled channel 0 drives its pins low
  AST_GATE0: assert property (!cmp_enable[0] |-> !cmp0_latched_out && !cmp0_raw_out)
    else $error("disabled output 0 not low");

  // unpowered core flags no edges
  AST_NO_EV_OFF: assert property (!cmp_enable[0] |-> !rise_ev[0] && !fall_ev[0])
    else $error("edge seen on disabled comparator");

  // fall flag with enable raises irq
  AST_IRQ: assert property (fall_flag[0] && fie[0] |-> cmp_irq[0])
    else $error("irq missing for fall flag");

  // rise flag with enable raises irq
  AST_IRQ_RISE1: assert property (rise_flag[1] && rie[1] |-> cmp_irq[1])
    else $error("irq missing for rise flag");

  // no flag, no irq
  AST_NOIRQ: assert property (!rise_flag[1] && !fall_flag[1] |-> !cmp_irq[1])
    else $error("irq without flag");

  // masked flags raise no irq
  AST_NOIRQ_MASK0: assert property (!(rise_flag[0] && rie[0]) && !(fall_flag[0] && fie[0])
                                    |-> !cmp_irq[0])
    else $error("irq despite masked flags");

  // response field forwarded to the core
  AST_RESP: assert property (wr_mode[0] |=> cmp_response_sel[1:0] == $past(pwdata[1:0]))
    else $error("response field not forwarded");

  // channel 1 response field forwarded
  AST_RSP1: assert property (wr_mode[1] |=> cmp_response_sel[3:2] == $past(pwdata[1:0]))
    else $error("response field 1 not forwarded");

  // positive hysteresis code passed unchanged
  AST_HYP0: assert property (wr_ctrl[0] |=> cmp_pos_hyst_sel[1:0] == $past(pwdata[3:2]))
    else $error("positive hysteresis not forwarded");

  // negative hysteresis code passed unchanged
  AST_HYN1: assert property (wr_ctrl[1] |=> cmp_neg_hyst_sel[3:2] == $past(pwdata[1:0]))
    else $error("negative hysteresis not forwarded");

  // channel 0 negative select follows writes
  AST_ISEL0: assert property (wr_isel[0] |=> cmp0_neg_input_sel == $past(pwdata[5:4]))
    else $error("negative input select not taken");

  // channel 1 positive select follows writes
  AST_ISEL1: assert property (wr_isel[1] |=> cmp1_pos_input_sel == $past(pwdata[1:0]))
    else $error("positive input select not taken");

  // enable bit reaches the core
  AST_EN: assert property (wr_ctrl[1] |=> cmp_enable[1] == $past(pwdata[7]))
    else $error("enable write not taken");

  // reset request only from an enabled channel 0
  AST_RST_REQ: assert property (cmp0_reset_req |-> cmp_enable[0] && !cmp0_latched_out)
    else $error("reset request while disabled");

  // read data carries the gated result
  AST_RESULT: assert property (rd_setup && hit_c1 |=> prdata[6] == $past(en_res[1]))
    else $error("result bit not read back");

  // main scenarios
  COV_RISE: cover property (rise_ev[0] ##1 rise_flag[0]);
  COV_CLR: cover property (rise_flag[1] ##1 wr_ctrl[1] ##1 !rise_flag[1]);
  COV_IRQ: cover property (cmp_irq[0] && cmp_irq[1]);
  COV_FALL: cover property (fall_ev[1] ##1 fall_flag[1]);
  COV_OFF: cover property (cmp_enable[0] ##1 !cmp_enable[0]);

endmodule

/* rtl/dcc_pkg.sv */
// dual comparator control package: register offsets, field positions, reset values
// assumes apb byte addressing with 32-bit data, registers in low 8 bits
package dcc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_MODE0 = 8'h04;
  localparam logic [7:0] OFF_ISEL0 = 8'h08;
  localparam logic [7:0] OFF_CTRL1 = 8'h10;
  localparam logic [7:0] OFF_MODE1 = 8'h14;
  localparam logic [7:0] OFF_ISEL1 = 8'h18;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_EN = 7;
  localparam int CTL_OUT = 6;
  localparam int CTL_RIF = 5;
  localparam int CTL_FIF = 4;
  localparam int CTL_HYP = 2;
  localparam int CTL_HYN = 0;

  // ----------------------------------------------------------------
  // mode and input-select fields
  // ----------------------------------------------------------------
  localparam int MD_RIE = 5;
  localparam int MD_FIE = 4;
  localparam int MD_RSP = 0;
  localparam int MX_NEG = 4;
  localparam int MX_POS = 0;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h02;
  localparam logic [7:0] RST_ISEL = 8'h00;
  localparam logic [7:0] MASK_MODE = 8'h33;
  localparam logic [7:0] MASK_ISEL = 8'h33;
  localparam logic [7:0] MASK_CTRL_WR = 8'h8f;

endpackage

/* tb/dcc_core_model.sv */
// analog comparator core pair model for the comparator control bench
// assumes the bench sets input voltages in mV and the design drives enables
`timescale 1ns/100ps
module dcc_core_model (
  input wire logic [1:0] en, // power-up from design
  input wire logic [1:0][7:0] vpos, // positive inputs, mV
  input wire logic [1:0][7:0] vneg, // negative inputs, mV
  output logic [1:0] raw // raw results
);
  // result high only while positive exceeds negative; unpowered core held low
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      raw[n] = en[n] ? (vpos[n] > vneg[n]) : 1'b0;
    end
  end
endmodule

/* tb/testbench.sv */
// self-checking bench for the dual comparator control block
// assumes dcc_pkg offsets and a core model on the raw inputs
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, cmp0_reset_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] raw_in, en, irq, lat, raw_o, p0, n0, p1, n1;
  logic [3:0] hp, hn, rs;
  logic [1:0][7:0] vpos, vneg;
  logic e;
  int n_errors, tests_run;
  dcc_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_raw_in(raw_in), .cmp_enable(en),
    .cmp0_pos_input_sel(p0), .cmp0_neg_input_sel(n0), .cmp1_pos_input_sel(p1),
    .cmp1_neg_input_sel(n1), .cmp_pos_hyst_sel(hp), .cmp_neg_hyst_sel(hn),
    .cmp_response_sel(rs), .cmp0_latched_out(lat[0]), .cmp1_latched_out(lat[1]),
    .cmp0_raw_out(raw_o[0]), .cmp1_raw_out(raw_o[1]), .cmp_irq(irq),
    .cmp0_reset_req(cmp0_reset_req));
  dcc_core_model i_cores (.en(en), .vpos(vpos), .vneg(vneg), .raw(raw_in));
  // clock at 50 MHz
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin n_errors++; end_of_test(); end
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, ex}, q)
  endtask
  // move one comparator's positive input, then let the result settle
  task automatic set_v(input int ch, input logic [7:0] v, input int w);
    @(posedge pclk);
    vpos[ch] <= v;
    #1;
    repeat (w) @(posedge pclk);
    #1;
  endtask
  initial begin
    logic [7:0] b;
    n_errors = 0; tests_run = 0; presetn = 1'b0; clk_en = 1'b1; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; vpos = '0; vneg = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("resp rst", 4'b1010, rs)
    for (int ch = 0; ch < 2; ch++) begin
      b = 8'(ch * 16);
      rd(b + dcc_pkg::OFF_CTRL0, 8'h00, "ctrl rst");
      rd(b + dcc_pkg::OFF_MODE0, 8'h02, "mode rst");
      rd(b + dcc_pkg::OFF_ISEL0, 8'h00, "isel rst");
      wr(b + dcc_pkg::OFF_ISEL0, ch ? 8'hd2 : 8'hf1);
      rd(b + dcc_pkg::OFF_ISEL0, ch ? 8'h12 : 8'h31, "isel");
      wr(b + dcc_pkg::OFF_MODE0, ch ? 8'hf1 : 8'hc3);
      wr(b + dcc_pkg::OFF_CTRL0, ch ? 8'hc6 : 8'h8b);
      rd(b + dcc_pkg::OFF_CTRL0, ch ? 8'h86 : 8'h8b, "ctrl");
    end
    `CHK("in sel", 8'h6d, {n1, p1, n0, p0})
    `CHK("hyst", 8'h6b, {hp, hn})
    `CHK("resp", 4'h7, rs)
    `CHK("enable", 2'b11, en)
    $display("test config done");
    for (int ch = 0; ch < 2; ch++) begin
      b = 8'(ch * 16);
      wr(b + dcc_pkg::OFF_MODE0, 8'h30);
      wr(b, 8'h80);
      set_v(ch, 8'd10, 0);
      `CHK("raw", 1'b1, raw_o[ch])
      set_v(ch, 8'd10, 4);
      `CHK("latched", 1'b1, lat[ch])
      `CHK("irq rise", 1'b1, irq[ch])
      rd(b, 8'he0, "rise");
      set_v(ch, 8'd0, 4);
      if (ch == 0) `CHK("reset req", 1'b1, cmp0_reset_req)
      rd(b, 8'hb0, "sticky");
      wr(b, 8'h80);
      wr(b + dcc_pkg::OFF_MODE0, 8'h10);
      set_v(ch, 8'd10, 4);
      `CHK("irq masked", 1'b0, irq[ch])
      wr(b, 8'h00);
      `CHK("pin low", 2'b00, {lat[ch], raw_o[ch]})
      rd(b, 8'h00, "off");
    end
    $display("test edges done");
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("slverr", 1'b1, e)
    `CHK("unmapped", 32'h0, q)
    $display("test unmapped done");
    end_of_test();
  end
endmodule
